/* logic/spimc_defines.vh */
// register map, field positions, reset values and timing of the spi mode control
// Function
// - with the transfer interrupt enable (bit 7) set, a done or fault flag raises the interrupt.
// - clearing the interface enable (bit 6) disables the block, forces idle and clears all status bits.
// - setting the interface enable hands the port pins over to the serial functions.
// - with the transmit-empty interrupt enable (bit 5) set, the tx empty flag raises the interrupt.
// - bit 4 selects the role, 0 peripheral and 1 controller that drives the serial clock.
// - any change of the role select bit forces the whole interface to idle.
// - bit 3 selects clock polarity, 0 rests low and 1 rests high while idle.
// - both ends of the link must use the same clock polarity.
// - as controller, a change of polarity, phase or select output enable aborts and forces idle.
// - bit 2 selects phase, 0 samples on odd edges 1 to 15 and 1 on even edges 2 to 16.
// - the select output enable (bit 1) drives select only as controller with fault detect enabled.
// - select is an input as peripheral; as controller unused, fault input or output per the enables.
// - bit 0 picks low bit first on the line only; as controller a change aborts and forces idle.
`ifndef SPIMC_DEFINES_VH
`define SPIMC_DEFINES_VH
// register byte offsets
`define SPIMC_OFS_CTRL1 8'h00
`define SPIMC_OFS_CTRL2 8'h04
`define SPIMC_OFS_DATA  8'h08
`define SPIMC_OFS_STAT  8'h0c
`define SPIMC_OFS_MASK  8'h10
// control one fields
`define SPIMC_B_TIE  7
`define SPIMC_B_EN   6
`define SPIMC_B_TXIE 5
`define SPIMC_B_ROLE 4
`define SPIMC_B_CLOCK_POLARITY_SELECT 3
`define SPIMC_B_CLOCK_PHASE_SELECT 2
`define SPIMC_B_SELECT_OUTPUT_ENABLE 1
`define SPIMC_B_LSBF 0
// control two field
`define SPIMC_B_FDEN 0
// status and mask fields
`define SPIMC_S_DONE  0
`define SPIMC_S_FAULT 1
`define SPIMC_S_TXE   2
// reset values
`define SPIMC_CTRL1_RST 8'h04
`define SPIMC_CTRL2_RST 1'h0
`define SPIMC_MASK_RST  3'h7
// timing: bus cycles per half serial clock, index of the last edge of a byte
`define SPIMC_HALF_DIV  3'h4
`define SPIMC_LAST_EDGE 5'h0f
// axi responses
`define SPIMC_RESP_OK  2'h0
`define SPIMC_RESP_ERR 2'h2
`endif

/* logic/spimc_top.v */
// spi mode control with axi4-lite registers, shifter and pin control
`timescale 1ns/10ps
`default_nettype none
`include "spimc_defines.vh"
module spimc_top (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address and data
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // interrupt and pin ownership
  output wire        irq,
  output wire        pins_serial_sel,
  // serial clock pin
  input  wire        sck_i,
  output wire        sck_o,
  output wire        sck_oe_n,
  // controller-out data pin
  input  wire        mosi_i,
  output wire        mosi_o,
  output wire        mosi_oe_n,
  // controller-in data pin
  input  wire        miso_i,
  output wire        miso_o,
  output wire        miso_oe_n,
  // select pin, active low
  input  wire        ss_n_i,
  output wire        ss_n_o,
  output wire        ss_n_oe_n
);

  // ****************************************
  // states and helpers
  // ****************************************
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN  = 2'b10;

  // mapped register offsets
  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a == `SPIMC_OFS_CTRL1) || (a == `SPIMC_OFS_CTRL2) ||
                (a == `SPIMC_OFS_DATA) || (a == `SPIMC_OFS_STAT) ||
                (a == `SPIMC_OFS_MASK);
    end
  endfunction

  // bit that goes on the line next
  function head_bit;
    input [7:0] v;
    input       lsb_first;
    begin
      head_bit = lsb_first ? v[0] : v[7];
    end
  endfunction

  // shifter with the sampled bit entered at the far end
  function [7:0] shift_in;
    input [7:0] v;
    input       b;
    input       lsb_first;
    begin
      shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
    end
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  reg        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  reg [1:0]  bresp_reg, rresp_reg;
  reg [7:0]  rdata_reg;
  reg        aw_have_reg, w_have_reg, w_strb_reg;
  reg [7:0]  aw_addr_reg, w_data_reg;
  reg [7:0]  ctrl1_reg, ctrl_prev_reg;
  reg        fden_reg;
  reg [2:0]  stat_reg, mask_reg;
  reg [7:0]  tx_buf_reg, rx_reg, sh_reg;
  reg        tx_full_reg;
  reg [1:0]  st_reg;
  reg [4:0]  cnt_reg;
  reg [2:0]  div_reg;
  reg        sck_reg, sdo_reg;
  reg [3:0]  s1_reg, s2_reg;
  reg        s3_sck_reg;
  reg        irq_reg, sel_reg;
  reg        sck_o_reg, sck_oe_n_reg, mosi_o_reg, mosi_oe_n_reg;
  reg        miso_o_reg, miso_oe_n_reg, ss_o_reg, ss_oe_n_reg;
  reg [7:0]  rd_mux;
  reg [2:0]  stat_next;

  wire       en   = ctrl1_reg[`SPIMC_B_EN];
  wire       role = ctrl1_reg[`SPIMC_B_ROLE];
  wire       clock_polarity_select = ctrl1_reg[`SPIMC_B_CLOCK_POLARITY_SELECT];
  wire       clock_phase_select = ctrl1_reg[`SPIMC_B_CLOCK_PHASE_SELECT];
  wire       select_output_enable = ctrl1_reg[`SPIMC_B_SELECT_OUTPUT_ENABLE];
  wire       lsbf = ctrl1_reg[`SPIMC_B_LSBF];
  wire [7:0] chg  = ctrl1_reg ^ ctrl_prev_reg;
  wire       idle = st_reg[0];
  wire       run  = st_reg[1];
  wire       wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
  wire       wr_ok   = wr_fire & w_strb_reg & addr_ok(aw_addr_reg);
  wire       rd_fire = s_axi_arvalid & arready_reg;
  wire       ss_low  = ~s2_reg[3];
  wire       sdi     = role ? s2_reg[2] : s2_reg[1];

  // ****************************************
  // axi4-lite slave
  // ****************************************

  // write channels taken in either order, answer after both
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `SPIMC_RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && awready_reg)
      begin
        aw_have_reg <= 1'b1;
        awready_reg <= 1'b0;
        aw_addr_reg <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && wready_reg)
      begin
        w_have_reg <= 1'b1;
        wready_reg <= 1'b0;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= addr_ok(aw_addr_reg) ? `SPIMC_RESP_OK
                                            : `SPIMC_RESP_ERR;
      end
      if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // read data select
  always @*
  begin
    case (s_axi_araddr[7:0])
      `SPIMC_OFS_CTRL1: rd_mux = ctrl1_reg;
      `SPIMC_OFS_CTRL2: rd_mux = {7'h00, fden_reg};
      `SPIMC_OFS_DATA:  rd_mux = rx_reg;
      `SPIMC_OFS_STAT:  rd_mux = {5'h00, stat_reg};
      `SPIMC_OFS_MASK:  rd_mux = {5'h00, mask_reg};
      default:          rd_mux = 8'h00;
    endcase
  end

  // read answers one cycle after the address
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 8'h00;
      rresp_reg   <= `SPIMC_RESP_OK;
    end
    else if (rd_fire)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_mux;
      rresp_reg   <= addr_ok(s_axi_araddr[7:0]) ? `SPIMC_RESP_OK
                                                : `SPIMC_RESP_ERR;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // ****************************************
  // control registers
  // ****************************************

  // control writable anytime, acts from the next edge
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl1_reg     <= `SPIMC_CTRL1_RST;
      ctrl_prev_reg <= `SPIMC_CTRL1_RST;
      fden_reg      <= `SPIMC_CTRL2_RST;
      mask_reg      <= `SPIMC_MASK_RST;
    end
    else
    begin
      ctrl_prev_reg <= ctrl1_reg;
      if (wr_ok && aw_addr_reg == `SPIMC_OFS_CTRL1)
        ctrl1_reg <= w_data_reg;
      if (wr_ok && aw_addr_reg == `SPIMC_OFS_CTRL2)
        fden_reg <= w_data_reg[`SPIMC_B_FDEN];
      if (wr_ok && aw_addr_reg == `SPIMC_OFS_MASK)
        mask_reg <= w_data_reg[2:0];
    end
  end

  // ****************************************
  // transfer engine
  // ****************************************
  wire fault = en & role & fden_reg & ~select_output_enable & ss_low;
  wire abort = ~en | chg[`SPIMC_B_ROLE] | fault |
               (role & (chg[`SPIMC_B_CLOCK_POLARITY_SELECT] | chg[`SPIMC_B_CLOCK_PHASE_SELECT] |
                        chg[`SPIMC_B_SELECT_OUTPUT_ENABLE] | chg[`SPIMC_B_LSBF]));
  wire ctl_edge = run & role & (div_reg == `SPIMC_HALF_DIV - 3'h1);
  wire per_edge = run & ~role & ss_low & (s2_reg[0] ^ s3_sck_reg);
  wire edge_hit = ctl_edge | per_edge;
  wire smp_edge = edge_hit & (cnt_reg[0] == clock_phase_select);
  wire start    = idle & en & ~abort &
                  (role ? tx_full_reg : ss_low);
  wire last     = edge_hit & (cnt_reg == `SPIMC_LAST_EDGE);
  wire per_quit = run & ~role & ~ss_low;
  wire data_wr  = wr_ok & (aw_addr_reg == `SPIMC_OFS_DATA);

  // pin input synchronisers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_reg     <= 4'hf;
      s2_reg     <= 4'hf;
      s3_sck_reg <= 1'b1; // matches the second stage, no false edge
    end
    else
    begin
      s1_reg     <= {ss_n_i, miso_i, mosi_i, sck_i};
      s2_reg     <= s1_reg;
      s3_sck_reg <= s2_reg[0];
    end
  end

  // state, shifter, divider and edge count
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg      <= ST_IDLE;
      cnt_reg     <= 5'h00;
      div_reg     <= 3'h0;
      sck_reg     <= 1'b0;
      sh_reg      <= 8'h00;
      sdo_reg     <= 1'b0;
      rx_reg      <= 8'h00;
      tx_buf_reg  <= 8'h00;
      tx_full_reg <= 1'b0;
    end
    else
    begin
      if (data_wr)
      begin
        tx_buf_reg  <= w_data_reg;
        tx_full_reg <= 1'b1;
      end
      case (st_reg)
        ST_IDLE:
        begin
          cnt_reg <= 5'h00;
          div_reg <= 3'h0;
          sck_reg <= 1'b0;
          if (start)
          begin
            st_reg      <= ST_RUN;
            sh_reg      <= tx_buf_reg;
            sdo_reg     <= head_bit(tx_buf_reg, lsbf);
            tx_full_reg <= data_wr;
          end
        end
        ST_RUN:
        begin
          if (abort || per_quit)
            st_reg <= ST_IDLE;
          else
          begin
            if (role)
              div_reg <= ctl_edge ? 3'h0 : div_reg + 3'h1;
            if (ctl_edge)
              sck_reg <= ~sck_reg;
            if (edge_hit)
              cnt_reg <= cnt_reg + 5'h01;
            // sample edges shift in, the others put out the next bit
            if (smp_edge)
              sh_reg <= shift_in(sh_reg, sdi, lsbf);
            else if (edge_hit)
              sdo_reg <= head_bit(sh_reg, lsbf);
            if (last)
            begin
              st_reg <= ST_IDLE;
              // without phase the eighth sample came one edge earlier
              rx_reg <= clock_phase_select ? shift_in(sh_reg, sdi, lsbf) : sh_reg;
            end
          end
        end
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // status and interrupt
  // ****************************************

  // sticky flags, write one clears, a set wins
  always @*
  begin
    stat_next = stat_reg;
    if (wr_ok && aw_addr_reg == `SPIMC_OFS_STAT)
      stat_next = stat_next & ~w_data_reg[2:0];
    if (data_wr)
      stat_next[`SPIMC_S_TXE] = 1'b0;
    if (last && !abort && !per_quit)
      stat_next[`SPIMC_S_DONE] = 1'b1;
    if (fault)
      stat_next[`SPIMC_S_FAULT] = 1'b1;
    if (start && tx_full_reg)
      stat_next[`SPIMC_S_TXE] = 1'b1;
    if (!en)
      stat_next = 3'h0;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_reg <= 3'h0;
      irq_reg  <= 1'b0;
    end
    else
    begin
      stat_reg <= stat_next;
      irq_reg  <= |(stat_reg & mask_reg & {ctrl1_reg[`SPIMC_B_TXIE],
                   ctrl1_reg[`SPIMC_B_TIE], ctrl1_reg[`SPIMC_B_TIE]});
    end
  end

  // ****************************************
  // pin drive
  // ****************************************

  // registered pin levels and enables, enables low while driving
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_reg       <= 1'b0;
      sck_o_reg     <= 1'b0;
      sck_oe_n_reg  <= 1'b1;
      mosi_o_reg    <= 1'b0;
      mosi_oe_n_reg <= 1'b1;
      miso_o_reg    <= 1'b0;
      miso_oe_n_reg <= 1'b1;
      ss_o_reg      <= 1'b1;
      ss_oe_n_reg   <= 1'b1;
    end
    else
    begin
      sel_reg       <= en;
      sck_o_reg     <= clock_polarity_select ^ sck_reg;
      sck_oe_n_reg  <= ~(en & role);
      mosi_o_reg    <= sdo_reg;
      mosi_oe_n_reg <= ~(en & role);
      miso_o_reg    <= sdo_reg;
      miso_oe_n_reg <= ~(en & ~role & ss_low);
      ss_o_reg      <= ~run | abort; // released as the clock rests
      ss_oe_n_reg   <= ~(en & role & fden_reg & select_output_enable);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready   = awready_reg;
  assign s_axi_wready    = wready_reg;
  assign s_axi_bresp     = bresp_reg;
  assign s_axi_bvalid    = bvalid_reg;
  assign s_axi_arready   = arready_reg;
  assign s_axi_rdata     = {24'h000000, rdata_reg};
  assign s_axi_rresp     = rresp_reg;
  assign s_axi_rvalid    = rvalid_reg;
  assign irq             = irq_reg;
  assign pins_serial_sel = sel_reg;
  assign sck_o           = sck_o_reg;
  assign sck_oe_n        = sck_oe_n_reg;
  assign mosi_o          = mosi_o_reg;
  assign mosi_oe_n       = mosi_oe_n_reg;
  assign miso_o          = miso_o_reg;
  assign miso_oe_n       = miso_oe_n_reg;
  assign ss_n_o          = ss_o_reg;
  assign ss_n_oe_n       = ss_oe_n_reg;

endmodule
`default_nettype wire

/* tb/spimc_peer.sv */
// remote serial peripheral model for the spi mode control bench
`timescale 1ns/10ps
`default_nettype none
module spimc_peer (
  // serial pins
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  output var  logic       miso,
  // setup and data
  input  wire logic       clock_polarity_select,
  input  wire logic       clock_phase_select,
  input  wire logic [7:0] tx_byte,
  output var  logic [7:0] rx_byte
);
  logic [7:0] sh;
  logic       act;
  // frame flag lags select within the same time step, so a last clock edge
  // that meets the deselect still counts
  always @(ss_n)
    act <= !ss_n;
  // load on select, flip released line on deselect
  initial miso = 1'b0;
  always @(ss_n)
    if (!ss_n)
    begin
      sh = tx_byte;
      if (!clock_phase_select)  // first bit out before the first edge
      begin
        miso = sh[7];
        sh = {sh[6:0], 1'b0};
      end
    end
    else
      miso = ~miso;
  // leading edge leaves rest level, sample or shift
  always @(sck)
    if (act)
    begin
      if ((sck != clock_polarity_select) != clock_phase_select)
        rx_byte = {rx_byte[6:0], mosi};
      else
      begin
        miso = sh[7];
        sh = {sh[6:0], 1'b0};
      end
    end
endmodule
`default_nettype wire

/* tb/spimc_chk.sv */
// assertions on the spi mode control ports
`timescale 1ns/10ps
`default_nettype none
module spimc_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // interrupt and pins
  input wire logic        irq,
  input wire logic        pins_serial_sel,
  input wire logic        sck_o,
  input wire logic        sck_oe_n,
  input wire logic        miso_oe_n,
  input wire logic        ss_n_o,
  input wire logic        ss_n_oe_n
);
  logic [4:0] edge_cnt_reg;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // serial clock edges within one select frame
  always_ff @(posedge aclk)
    if (!aresetn || ss_n_o)
      edge_cnt_reg <= 5'h00;
    else if ($changed(sck_o))
      edge_cnt_reg <= edge_cnt_reg + 5'h01;
  // bus takes
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (s_rd_take |=> s_axi_rvalid
    && s_axi_rdata[31:8] == 24'h0) else $error("read answer wrong");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped");
  chk_pins_release: assert property (!pins_serial_sel [*2]
    |-> sck_oe_n && miso_oe_n && ss_n_oe_n) else $error("pin driven");
  chk_role_pins: assert property (!sck_oe_n |-> miso_oe_n)
    else $error("controller drives miso");
  chk_select_out: assert property (!ss_n_oe_n |-> !sck_oe_n)
    else $error("select driven as peripheral");
  chk_irq_off: assert property (!pins_serial_sel [*3] |-> !irq)
    else $error("irq while disabled");
  chk_half_period: assert property ($changed(sck_o) && !ss_n_o
    |=> ($stable(sck_o) || ss_n_o) [*3]) else $error("short half period");
  chk_edge_count: assert property (edge_cnt_reg <= 5'h10)
    else $error("too many clock edges");
endmodule
`default_nettype wire

/* tb/spi_mode_control_test.sv */
// self-checking bench for the spi mode control
`timescale 1ns/10ps
`default_nettype none
module spi_mode_control_test;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        pins_serial_sel, sck_o, sck_oe_n, mosi_o, mosi_oe_n;
  logic        miso_o, miso_oe_n, ss_n_o, ss_n_oe_n, peer_miso;
  logic        ss_low, clock_polarity_select, clock_phase_select;
  logic [7:0]  peer_rx, c;
  logic [7:0]  modes [5] = '{8'h52, 8'h5a, 8'h56, 8'h5e, 8'h53};
  logic [7:0]  aborts [4] = '{8'h5a, 8'h42, 8'h50, 8'h53};
  int          error_cnt, checked, i, k;
  // wire levels from all drivers, undriven data lines flip
  wire         sck_i  = sck_oe_n ? clock_polarity_select : sck_o;
  wire         ss_n_i = !ss_low && (ss_n_oe_n || ss_n_o);
  wire         mosi_i = mosi_oe_n ? ~mosi_o : mosi_o;
  wire         miso_i = miso_oe_n ? peer_miso : miso_o;
  spimc_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq, .pins_serial_sel, .sck_i, .sck_o, .sck_oe_n, .mosi_i, .mosi_o,
    .mosi_oe_n, .miso_i, .miso_o, .miso_oe_n, .ss_n_i, .ss_n_o, .ss_n_oe_n);
  spimc_peer i_peer (.sck(sck_i), .ss_n(ss_n_i), .mosi(mosi_i),
    .miso(peer_miso), .clock_polarity_select, .clock_phase_select, .tx_byte(8'h96), .rx_byte(peer_rx));
  // bus clock
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // register write, result code left in r
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  // register read into d and r
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    cmp(d, exp);
  endtask
  // register effect plus irq register settle
  task automatic gap;
    repeat (3) @(posedge aclk);
  endtask
  task automatic wait_done;
    d = 32'h0;
    for (k = 0; k < 60 && d[0] !== 1'b1; k++)
      rd(8'h0c);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    final_report;
  end
  // test sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, ss_low, clock_polarity_select, clock_phase_select} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    error_cnt = 0;
    checked = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h00, 32'h04);
    rchk(8'h10, 32'h07);
    rchk(8'h14, 32'h00);
    cmp(r, 32'h2);
    wr(8'h14, 8'hff);
    cmp(r, 32'h2);
    wr(8'h00, 8'h2c);
    rchk(8'h00, 32'h2c);
    cmp(pins_serial_sel, 32'h0);
    wr(8'h00, 8'h52);
    gap;
    cmp(pins_serial_sel, 32'h1);
    cmp(ss_n_oe_n, 32'h1);
    wr(8'h00, 8'h42);
    gap;
    cmp(sck_oe_n, 32'h1);
    cmp(ss_n_oe_n, 32'h1);
    cmp(mosi_oe_n, 32'h1);
    ss_low <= 1'b1;
    gap;
    gap;
    cmp(miso_oe_n, 32'h0);
    ss_low <= 1'b0;
    gap;
    gap;
    wr(8'h04, 8'h01);
    wr(8'h00, 8'h52);
    gap;
    cmp(sck_oe_n, 32'h0);
    cmp(ss_n_oe_n, 32'h0);
    cmp(mosi_oe_n, 32'h0);
    cmp(miso_oe_n, 32'h1);
    // one byte in each clock format and bit order
    for (i = 0; i < 5; i++)
    begin
      c = modes[i];
      wr(8'h00, c);
      clock_polarity_select <= c[3];
      clock_phase_select <= c[2];
      gap;
      cmp(sck_i, c[3]);
      wr(8'h08, 8'hc1);
      wait_done;
      cmp(peer_rx, c[0] ? 8'h83 : 8'hc1);
      rchk(8'h08, c[0] ? 8'h69 : 8'h96);
      rchk(8'h0c, 32'h05);
      if (i < 4) wr(8'h0c, 8'h07);
    end
    // interrupt enables and mask
    cmp(irq, 32'h0);
    wr(8'h00, 8'hd3);
    gap;
    cmp(irq, 32'h1);
    wr(8'h10, 8'h06);
    gap;
    cmp(irq, 32'h0);
    wr(8'h10, 8'h07);
    wr(8'h00, 8'h73);
    gap;
    cmp(irq, 32'h1);
    wr(8'h0c, 8'h04);
    gap;
    cmp(irq, 32'h0);
    wr(8'h00, 8'h13);
    rchk(8'h0c, 32'h00);
    cmp(pins_serial_sel, 32'h0);
    // setting changes in mid-transfer
    for (i = 0; i < 4; i++)
    begin
      wr(8'h00, 8'h52);
      wr(8'h0c, 8'h07);
      wr(8'h08, 8'h5a);
      for (k = 0; k < 50 && ss_n_i !== 1'b0; k++)
        @(posedge aclk);
      repeat (20) @(posedge aclk);
      wr(8'h00, aborts[i]);
      gap;
      cmp(ss_n_i, 32'h1);
      rd(8'h0c);
      cmp(d[0], 32'h0);
    end
    // select pulled low while controller watches for faults
    wr(8'h00, 8'hd0);
    wr(8'h0c, 8'h07);
    ss_low <= 1'b1;
    gap;
    rchk(8'h0c, 32'h02);
    cmp(irq, 32'h1);
    ss_low <= 1'b0;
    final_report;
  end
endmodule
bind spimc_top spimc_chk i_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .irq, .pins_serial_sel, .sck_o, .sck_oe_n, .miso_oe_n, .ss_n_o, .ss_n_oe_n);
`default_nettype wire
